// *** design/pap_protect.sv ***
// power amplifier protection: average power detectors, pin routing, tx gating
//
// Contract
// - long detector runs only when enabled
// - long power compared to 13-bit threshold
// - protection clock period from interpolation settings
// - long window is 2^(9+code) ticks
// - long result reads I^2+Q^2 from 6 msbs
// - short detector runs when enabled or when the global short bit is set
// - short power compared to 13-bit threshold
// - short window is 2^code ticks
// - short result reads I^2+Q^2 from 6 msbs
// - tx gate machine runs only when enabled
// - route short, long, crc errors to pin
// - route code-group link errors to pin
// - route blanking machine to pin
// - route tx gate machine to pin
// - software force drives pin high only while routing enable bit 7 is also set
// - route slew rate errors to pin
// - software tx enable used only when overriding
// - global bit turns on short protection
// - power errors start soft-off when enabled
// - tx enable fall starts soft-off when enabled
`timescale 1ns/1ps
`default_nettype none
module pap_protect #(
   parameter int unsigned LONG_EXP_BASE = pap_pkg::LONG_BASE_EXP // long window base exponent
) (
   input wire logic clk_sys, // converter-rate system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic ce, // clock enable, freezes all state but the reset synchroniser when low
   input wire logic reg_wr_en, // register write strobe
   input wire logic reg_rd_en, // register read strobe
   input wire logic [pap_pkg::ADDR_W-1:0] reg_addr, // register offset
   input wire logic [pap_pkg::DATA_W-1:0] reg_wdata, // register write data
   output logic [pap_pkg::DATA_W-1:0] reg_rdata, // register read data
   input wire logic [15:0] dac_i, // in-phase datapath word
   input wire logic [15:0] dac_q, // quadrature datapath word
   input wire logic [7:0] coarse_interp, // coarse interpolation factor
   input wire logic [7:0] fine_interp, // fine interpolation factor
   input wire logic tx_enable_in, // transmit enable input
   input wire logic sync_rotate_in, // sync logic rotation in progress
   input wire logic link_crc_error_in, // 64b/66b link crc error
   input wire logic link_code_error_in, // 8b/10b link error
   input wire logic slew_error_in, // slew rate error
   output logic protect_output_pin, // amplifier protection pin
   output logic fade_start, // soft-off request pulse
   output logic tx_enable_out, // transmit enable after override
   output logic flush_enable, // flush enable field
   output logic short_error, // short window error flag
   output logic long_error // long window error flag
);
   import pap_pkg::*;

   // all registered state of the block except the reset synchroniser
   typedef struct packed {
      logic [7:0] long_limit_lo; // long threshold low byte
      logic [4:0] long_limit_hi; // long threshold high field
      logic long_detector_on; // long detector enable
      logic [3:0] long_window_length_code; // long window code
      logic [7:0] short_limit_lo; // short threshold low byte
      logic [4:0] short_limit_hi; // short threshold high field
      logic short_detector_on; // short detector enable
      logic [1:0] short_window_length_code; // short window code
      logic short_protect_global_on; // global short enable
      logic tx_gate_fsm_on; // tx gate machine enable
      logic [7:0] route_a; // routing bits of the first routing register
      logic route_slew_error; // slew routing bit
      logic sw_tx_gate; // software tx enable
      logic sw_tx_gate_override; // software tx enable override
      logic flush_en; // flush enable
      logic short_error_fade_on; // short error soft-off source
      logic long_error_fade_on; // long error soft-off source
      logic txen_fade_on; // tx enable fall soft-off source
      logic [10:0] pa_cnt; // protection clock divider
      logic [36:0] long_acc; // long window accumulator
      logic [23:0] long_cnt; // ticks seen in long window
      logic [12:0] long_window_result; // last long average
      logic long_err; // long error flag
      logic [15:0] short_acc; // short window accumulator
      logic [2:0] short_cnt; // ticks seen in short window
      logic [12:0] short_window_result; // last short average
      logic short_err; // short error flag
      pap_tg_t tg; // tx gate machine state
      logic txctl_prev; // previous tx control level
      logic blank; // blanking machine output
      logic pin; // protection pin
      logic fade; // soft-off pulse
      logic txout; // gated tx enable
      logic [7:0] rdata; // read data
   } pap_state_t;

   pap_state_t q; // current state
   pap_state_t d; // next state
   logic [1:0] rst_sync; // reset release synchroniser
   logic rst_n; // synchronised reset

   // power of one sample from the six msbs of each word
   function automatic logic [12:0] pap_power(input logic [15:0] iw, input logic [15:0] qw);
      logic signed [5:0] is;
      logic signed [5:0] qs;
      logic [11:0] ip;
      logic [11:0] qp;
      is = iw[15 -: PWR_MSBS];
      qs = qw[15 -: PWR_MSBS];
      ip = 12'($signed(is) * $signed(is));
      qp = 12'($signed(qs) * $signed(qs));
      return {1'b0, ip} + {1'b0, qp};
   endfunction

   // protection clock period in converter clocks, never below one
   function automatic logic [10:0] pap_period(input logic [7:0] co, input logic [7:0] fi);
      logic [10:0] p;
      if (co != 8'h01) begin
         p = 11'(PA_MULT_COARSE * {3'h0, co});
      end else if (fi != 8'h01) begin
         p = 11'(PA_MULT_FINE * {3'h0, co});
      end else begin
         p = PA_PERIOD_FIXED;
      end
      return (p == 11'h000) ? 11'h001 : p;
   endfunction

   logic [12:0] sample_pwr; // power of the present sample
   logic [10:0] pa_period; // present tick period
   logic pa_tick; // one protection clock period elapsed
   logic tx_ctrl; // tx enable after override selection
   logic tx_fall; // falling edge of tx control
   logic short_run; // short detector active
   logic [4:0] long_shift; // long window exponent
   logic [23:0] long_last; // last tick index of long window
   logic [2:0] short_last; // last tick index of short window
   logic [36:0] long_total; // long sum including this tick
   logic [15:0] short_total; // short sum including this tick
   logic long_end; // long window closes this tick
   logic short_end; // short window closes this tick
   logic [12:0] long_avg; // long average at window end
   logic [12:0] short_avg; // short average at window end
   logic sw_force_on; // software force of the pin, both bits high

   assign sample_pwr = pap_power(dac_i, dac_q);
   assign pa_period = pap_period(coarse_interp, fine_interp);
   assign pa_tick = (q.pa_cnt >= pa_period - 11'h001);
   assign tx_ctrl = q.sw_tx_gate_override ? q.sw_tx_gate : tx_enable_in;
   assign tx_fall = q.txctl_prev & ~tx_ctrl;
   assign short_run = q.short_detector_on | q.short_protect_global_on;
   assign long_shift = 5'(LONG_EXP_BASE) + {1'b0, q.long_window_length_code};
   assign long_last = 24'((25'h1 << long_shift) - 25'h1);
   assign short_last = 3'((4'h1 << q.short_window_length_code) - 4'h1);
   assign long_total = q.long_acc + {24'h0, sample_pwr};
   assign short_total = q.short_acc + {3'h0, sample_pwr};
   assign long_end = pa_tick && (q.long_cnt == long_last);
   assign short_end = pa_tick && (q.short_cnt == short_last);
   assign long_avg = 13'(long_total >> long_shift);
   assign short_avg = 13'(short_total >> q.short_window_length_code);
   assign sw_force_on = q.route_a[BIT_RT_SWF] & q.route_a[BIT_SW_FORCE];

   // two-stage release of the asynchronous reset
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // next-state logic for the whole block
   always_comb begin
      d = q;
      // protection clock divider
      d.pa_cnt = pa_tick ? 11'h000 : q.pa_cnt + 11'h001;
      // long window detector
      if (!q.long_detector_on) begin
         // detection off
         d.long_acc = '0;
         d.long_cnt = '0;
         d.long_err = 1'b0;
      end else if (long_end) begin
         // window complete: publish average and compare
         d.long_window_result = long_avg;
         d.long_err = long_avg > {q.long_limit_hi, q.long_limit_lo};
         d.long_acc = '0;
         d.long_cnt = '0;
      end else if (pa_tick) begin
         // accumulate one sample per protection tick
         d.long_acc = long_total;
         d.long_cnt = q.long_cnt + 24'h1;
      end
      // short window detector
      if (!short_run) begin
         // detection off
         d.short_acc = '0;
         d.short_cnt = '0;
         d.short_err = 1'b0;
      end else if (short_end) begin
         // window complete: publish average and compare
         d.short_window_result = short_avg;
         d.short_err = short_avg > {q.short_limit_hi, q.short_limit_lo};
         d.short_acc = '0;
         d.short_cnt = '0;
      end else if (pa_tick) begin
         // accumulate one sample per protection tick
         d.short_acc = short_total;
         d.short_cnt = q.short_cnt + 3'h1;
      end
      // tx gate state machine
      d.txctl_prev = tx_ctrl;
      d.txout = tx_ctrl;
      unique case (q.tg)
         TG_IDLE: begin
            // parked until enabled
            if (q.tx_gate_fsm_on) begin
               d.tg = tx_ctrl ? TG_ON : TG_OFF;
            end
         end
         TG_ON: begin
            // transmitting
            if (!q.tx_gate_fsm_on) begin
               d.tg = TG_IDLE;
            end else if (!tx_ctrl) begin
               d.tg = TG_OFF;
            end
         end
         TG_OFF: begin
            // transmit off, amplifier protected
            if (!q.tx_gate_fsm_on) begin
               d.tg = TG_IDLE;
            end else if (tx_ctrl) begin
               d.tg = TG_ON;
            end
         end
         default: begin
            d.tg = TG_IDLE;
         end
      endcase
      // blanking: during rotations and after tx enable falls until it returns
      d.blank = sync_rotate_in | tx_fall | (q.blank & ~tx_ctrl);
      // protection pin is the or of enabled sources
      d.pin = (q.route_a[BIT_RT_SHORT] & q.short_err)
         | (q.route_a[BIT_RT_LONG] & q.long_err)
         | (q.route_a[BIT_RT_CRC] & link_crc_error_in)
         | (q.route_a[BIT_RT_CODE] & link_code_error_in)
         | (q.route_a[BIT_RT_BLANK] & q.blank)
         | (q.route_a[BIT_RT_TXFSM] & (q.tg == TG_OFF))
         | sw_force_on
         | (q.route_slew_error & slew_error_in);
      // soft-off request on a new power error or a tx enable fall
      d.fade = (q.short_error_fade_on & d.short_err & ~q.short_err)
         | (q.long_error_fade_on & d.long_err & ~q.long_err)
         | (q.txen_fade_on & tx_fall);
      // register writes
      if (reg_wr_en) begin
         unique case (reg_addr)
            OFS_FADE_SOURCE: begin
               d.short_error_fade_on = reg_wdata[BIT_FADE_SHORT];
               d.long_error_fade_on = reg_wdata[BIT_FADE_LONG];
               d.txen_fade_on = reg_wdata[BIT_FADE_TXEN];
            end
            OFS_COMMON_CONTROL: begin
               d.short_protect_global_on = reg_wdata[BIT_GLOBAL_SHORT];
            end
            OFS_LONG_THR_LOW: begin
               d.long_limit_lo = reg_wdata;
            end
            OFS_LONG_THR_HIGH: begin
               d.long_limit_hi = reg_wdata[4:0];
            end
            OFS_LONG_CONTROL: begin
               d.long_detector_on = reg_wdata[BIT_DET_ON];
               d.long_window_length_code = reg_wdata[3:0];
            end
            OFS_SHORT_THR_LOW: begin
               d.short_limit_lo = reg_wdata;
            end
            OFS_SHORT_THR_HIGH: begin
               d.short_limit_hi = reg_wdata[4:0];
            end
            OFS_SHORT_CONTROL: begin
               d.short_detector_on = reg_wdata[BIT_DET_ON];
               d.short_window_length_code = reg_wdata[1:0];
            end
            OFS_TX_FSM_CONTROL: begin
               d.tx_gate_fsm_on = reg_wdata[BIT_TX_FSM_ON];
            end
            OFS_ROUTING_A: begin
               d.route_a = reg_wdata;
            end
            OFS_ROUTING_B: begin
               d.route_slew_error = reg_wdata[BIT_RT_SLEW];
            end
            OFS_BLANKING: begin
               d.sw_tx_gate = reg_wdata[BIT_SW_TXEN];
               d.sw_tx_gate_override = reg_wdata[BIT_SW_OVERRIDE];
            end
            OFS_FLUSH: begin
               d.flush_en = reg_wdata[BIT_FLUSH];
            end
            default: begin
               // unmapped writes are ignored
            end
         endcase
      end
      // register reads, one cycle late
      if (reg_rd_en) begin
         unique case (reg_addr)
            OFS_FADE_SOURCE: d.rdata = {q.short_error_fade_on, q.long_error_fade_on, 4'h0,
               q.txen_fade_on, 1'b0};
            OFS_COMMON_CONTROL: d.rdata = {7'h00, q.short_protect_global_on};
            OFS_LONG_THR_LOW: d.rdata = q.long_limit_lo;
            OFS_LONG_THR_HIGH: d.rdata = {3'h0, q.long_limit_hi};
            OFS_LONG_CONTROL: d.rdata = {q.long_detector_on, 3'h0, q.long_window_length_code};
            OFS_LONG_PWR_LOW: d.rdata = q.long_window_result[7:0];
            OFS_LONG_PWR_HIGH: d.rdata = {3'h0, q.long_window_result[12:8]};
            OFS_SHORT_THR_LOW: d.rdata = q.short_limit_lo;
            OFS_SHORT_THR_HIGH: d.rdata = {3'h0, q.short_limit_hi};
            OFS_SHORT_CONTROL: d.rdata = {q.short_detector_on, 5'h00,
               q.short_window_length_code};
            OFS_SHORT_PWR_LOW: d.rdata = q.short_window_result[7:0];
            OFS_SHORT_PWR_HIGH: d.rdata = {3'h0, q.short_window_result[12:8]};
            OFS_TX_FSM_CONTROL: d.rdata = {7'h00, q.tx_gate_fsm_on};
            OFS_ROUTING_A: d.rdata = q.route_a;
            OFS_ROUTING_B: d.rdata = {5'h00, q.route_slew_error, 2'b00};
            OFS_BLANKING: d.rdata = {4'h0, q.sw_tx_gate, q.sw_tx_gate_override, 2'b00};
            OFS_FLUSH: d.rdata = {7'h00, q.flush_en};
            default: d.rdata = 8'h00;
         endcase
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.tg <= TG_IDLE;
         q.short_error_fade_on <= RST_FADE_SHORT;
         q.long_error_fade_on <= RST_FADE_LONG;
         q.txen_fade_on <= RST_FADE_TXEN;
         q.flush_en <= RST_FLUSH;
      end else if (ce) begin
         q <= d;
      end
   end

   // outputs straight from state
   assign reg_rdata = q.rdata;
   assign protect_output_pin = q.pin;
   assign fade_start = q.fade;
   assign tx_enable_out = q.txout;
   assign flush_enable = q.flush_en;
   assign short_error = q.short_err;
   assign long_error = q.long_err;

   // checks on the block's own behaviour
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   AST_PERIOD: assert property (q.pa_cnt < pa_period)
      else $error("protection divider beyond its period");
   AST_LONG_OFF: assert property (ce && !q.long_detector_on |=> !long_error)
      else $error("long error while detector off");
   AST_SHORT_OFF: assert property (ce && !short_run |=> !short_error && q.short_cnt == 3'h0)
      else $error("short detector active while off");
   AST_GLOBAL: assert property (ce && q.short_protect_global_on && short_end &&
      short_avg > {q.short_limit_hi, q.short_limit_lo} |=> short_error)
      else $error("global enable did not run short detector");
   AST_SHORT_W0: assert property (ce && short_run && q.short_window_length_code == 2'b00
      && pa_tick |=> q.short_window_result == $past(sample_pwr))
      else $error("single tick short window mismatch");
   AST_LONG_CMP: assert property (ce && q.long_detector_on && long_end |=>
      long_error == (q.long_window_result > {q.long_limit_hi, q.long_limit_lo}))
      else $error("long compare wrong");
   AST_SHORT_CMP: assert property (ce && short_run && short_end |=>
      short_error == (q.short_window_result > {q.short_limit_hi, q.short_limit_lo}))
      else $error("short compare wrong");
   AST_TG_IDLE: assert property (ce && !q.tx_gate_fsm_on |=> q.tg == TG_IDLE)
      else $error("tx gate machine runs while disabled");
   AST_OVERRIDE: assert property (ce && q.sw_tx_gate_override |=>
      tx_enable_out == $past(q.sw_tx_gate))
      else $error("software tx enable not applied");
   AST_PIN_IDLE: assert property (ce && q.route_a == 8'h00 && !q.route_slew_error
      |=> !protect_output_pin)
      else $error("pin high with no source routed");
   AST_PIN_LONG: assert property (ce && q.route_a[BIT_RT_LONG] && q.long_err
      |=> protect_output_pin)
      else $error("long error not routed");
   AST_SW_FORCE: assert property (ce && sw_force_on |=> protect_output_pin)
      else $error("software force did not raise pin");
   AST_FADE_TXEN: assert property (ce && q.txen_fade_on && tx_fall |=> fade_start)
      else $error("tx enable fall gave no soft-off");
   AST_FADE_PULSE: assert property (fade_start && !$past(fade_start) && ce |=> !fade_start
      || $past(tx_fall))
      else $error("soft-off held without cause");

   COV_PIN: cover property (!protect_output_pin ##1 protect_output_pin);
   COV_FADE: cover property (fade_start);
   COV_LONG_ERR: cover property (!long_error ##1 long_error);
   COV_TG: cover property (q.tg == TG_ON ##1 q.tg == TG_OFF);
endmodule
`default_nettype wire

// *** design/pap_pkg.sv ***
// constants shared by the power amplifier protection block
package pap_pkg;
   // register bus geometry
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [15:0] OFS_COMMON_CONTROL = 16'h0304;
   localparam logic [15:0] OFS_FADE_SOURCE = 16'h0301;
   localparam logic [15:0] OFS_LONG_THR_LOW = 16'h0305;
   localparam logic [15:0] OFS_LONG_THR_HIGH = 16'h0306;
   localparam logic [15:0] OFS_LONG_CONTROL = 16'h0307;
   localparam logic [15:0] OFS_LONG_PWR_LOW = 16'h0308;
   localparam logic [15:0] OFS_LONG_PWR_HIGH = 16'h0309;
   localparam logic [15:0] OFS_SHORT_THR_LOW = 16'h030a;
   localparam logic [15:0] OFS_SHORT_THR_HIGH = 16'h030b;
   localparam logic [15:0] OFS_SHORT_CONTROL = 16'h030c;
   localparam logic [15:0] OFS_SHORT_PWR_LOW = 16'h030d;
   localparam logic [15:0] OFS_SHORT_PWR_HIGH = 16'h030e;
   localparam logic [15:0] OFS_TX_FSM_CONTROL = 16'h030f;
   localparam logic [15:0] OFS_ROUTING_A = 16'h031f;
   localparam logic [15:0] OFS_ROUTING_B = 16'h0320;
   localparam logic [15:0] OFS_BLANKING = 16'h0321;
   localparam logic [15:0] OFS_FLUSH = 16'h0322;
   // field positions
   localparam int BIT_DET_ON = 7;
   localparam int BIT_GLOBAL_SHORT = 0;
   localparam int BIT_FADE_SHORT = 7;
   localparam int BIT_FADE_LONG = 6;
   localparam int BIT_FADE_TXEN = 1;
   localparam int BIT_TX_FSM_ON = 0;
   localparam int BIT_RT_SHORT = 6;
   localparam int BIT_RT_LONG = 5;
   localparam int BIT_RT_CRC = 4;
   localparam int BIT_RT_CODE = 3;
   localparam int BIT_RT_BLANK = 2;
   localparam int BIT_RT_TXFSM = 1;
   localparam int BIT_SW_FORCE = 0;
   localparam int BIT_RT_SWF = 7; // software force routing enable, spare writable bit
   localparam int BIT_RT_SLEW = 2;
   localparam int BIT_SW_TXEN = 3;
   localparam int BIT_SW_OVERRIDE = 2;
   localparam int BIT_FLUSH = 0;
   // reset values of the non-zero fields
   localparam logic RST_FADE_SHORT = 1'b1;
   localparam logic RST_FADE_LONG = 1'b1;
   localparam logic RST_FADE_TXEN = 1'b1;
   localparam logic RST_FLUSH = 1'b1;
   // protection clock period multipliers, in converter clocks
   localparam logic [10:0] PA_MULT_COARSE = 11'd4;
   localparam logic [10:0] PA_MULT_FINE = 11'd8;
   localparam logic [10:0] PA_PERIOD_FIXED = 11'd32;
   // long window exponent base
   localparam int LONG_BASE_EXP = 9;
   // number of datapath msbs used for power
   localparam int PWR_MSBS = 6;
   // transmit gate state machine, one-hot
   typedef enum logic [2:0] {
      TG_IDLE = 3'b001,
      TG_ON = 3'b010,
      TG_OFF = 3'b100
   } pap_tg_t;
endpackage

// *** bench/pap_amp_model.sv ***
// behavioural amplifier that mutes while the protection pin is high
`timescale 1ns/1ps
`default_nettype none
module pap_amp_model (
   input wire logic clk_sys, // system clock
   input wire logic protect_output_pin, // protection request
   output logic muted // output stage held off
);
   // bias switch lags the pin by one clock
   always_ff @(posedge clk_sys) begin
      muted <= protect_output_pin;
   end
endmodule
`default_nettype wire

// *** bench/pap_protect_test.sv ***
// self-checking bench for the amplifier protection block
`timescale 1ns/1ps
`default_nettype none
module pap_protect_test;
   import pap_pkg::*;
   logic clk_sys = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [15:0] addr = 16'h0000, di = 16'h0000, dq = 16'h0000;
   logic [7:0] wd = 8'h00, rdat;
   logic txi = 1'b0, rot = 1'b0, crc = 1'b0, cde = 1'b0, slew = 1'b0;
   logic [7:0] co = 8'h02, fi = 8'h01;
   logic pin, fade, txo, flush, serr, lerr, muted;
   int error_cnt = 0, compares = 0, fades = 0;
   // table offsets and writable masks
   logic [15:0] ofs [10] = '{16'h0305, 16'h0306, 16'h0307, 16'h030a, 16'h030b,
      16'h030c, 16'h030f, 16'h0320, 16'h0321, 16'h0322};
   logic [7:0] msk [10] = '{8'hff, 8'h1f, 8'h8f, 8'hff, 8'h1f, 8'h83, 8'h01, 8'h04,
      8'h0c, 8'h01};
   always #12.5 clk_sys = ~clk_sys;
   // short long window keeps the run brief
   pap_protect #(.LONG_EXP_BASE(1)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1),
      .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat),
      .dac_i(di), .dac_q(dq), .coarse_interp(co), .fine_interp(fi),
      .tx_enable_in(txi), .sync_rotate_in(rot), .link_crc_error_in(crc),
      .link_code_error_in(cde), .slew_error_in(slew), .protect_output_pin(pin),
      .fade_start(fade), .tx_enable_out(txo), .flush_enable(flush), .short_error(serr),
      .long_error(lerr));
   pap_amp_model amp (.clk_sys(clk_sys), .protect_output_pin(pin), .muted(muted));
   // count soft-off request pulses
   always @(posedge clk_sys) begin
      if (fade === 1'b1) fades++;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   // protection tick period in converter clocks
   function automatic int pa_per(input int c, input int f);
      return (c != 1) ? 4 * c : (f != 1) ? 8 * c : 32;
   endfunction
   task automatic wrr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      wr = 1'b1;
      addr = a;
      wd = d;
      @(negedge clk_sys);
      wr = 1'b0;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      @(negedge clk_sys);
      rd = 1'b1;
      addr = a;
      @(negedge clk_sys);
      rd = 1'b0;
      @(negedge clk_sys);
      chk8(rdat, e);
   endtask
   task automatic results;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard, far beyond the expected few thousand cycles
   initial begin
      #(25 * 40000);
      error_cnt++;
      $display("ERROR %0t: watchdog expired", $time);
      results();
   end
   initial begin
      int a, b, sa, sb, c, p, t, e, seen, n, nl, per;
      void'($urandom(32'h33d3));
      seen = 0;
      repeat (16) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk1(flush, 1'b1);
      foreach (ofs[k]) rdc(ofs[k], (k == 9) ? 8'h01 : 8'h00);
      rdc(16'h0400, 8'h00);
      // random write and readback, reserved bits read zero
      foreach (ofs[k]) begin
         p = $urandom;
         wrr(ofs[k], p[7:0]);
         rdc(ofs[k], p[7:0] & msk[k]);
         wrr(ofs[k], 8'h00);
      end
      // crc, code-group, blanking and slew sources each reach the pin only when routed
      for (int k = 0; k < 4; k++) begin
         {crc, cde, rot, slew} = 4'b1000 >> k;
         repeat (3) @(negedge clk_sys);
         chk1(pin, 1'b0);
         wrr((k == 3) ? OFS_ROUTING_B : OFS_ROUTING_A, (k == 3) ? 8'h04 : 8'h10 >> k);
         repeat (3) @(negedge clk_sys);
         chk1(pin, 1'b1);
         wrr((k == 3) ? OFS_ROUTING_B : OFS_ROUTING_A, 8'h00);
         {crc, cde, rot, slew} = 4'b0000;
      end
      wrr(OFS_ROUTING_A, 8'h01);
      repeat (3) @(negedge clk_sys);
      chk1(pin, 1'b0);
      wrr(OFS_ROUTING_A, 8'h81);
      repeat (3) @(negedge clk_sys);
      chk1(pin, 1'b1);
      // tx gate machine off state reaches the pin while enabled
      wrr(OFS_TX_FSM_CONTROL, 8'h01);
      wrr(OFS_ROUTING_A, 8'h02);
      repeat (3) @(negedge clk_sys);
      chk1(pin, 1'b1);
      wrr(OFS_TX_FSM_CONTROL, 8'h00);
      repeat (3) @(negedge clk_sys);
      chk1(pin, 1'b0);
      wrr(OFS_ROUTING_A, 8'h00);
      // software override of transmit enable
      wrr(OFS_BLANKING, 8'h0c);
      repeat (3) @(negedge clk_sys);
      chk1(txo, 1'b1);
      wrr(OFS_BLANKING, 8'h08);
      txi = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk1(txo, 1'b1);
      txi = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk1(txo, 1'b0);
      fades = 0;
      // detectors on constant data, low bits must not count
      for (int k = 0; k < 3; k++) begin
         co = (k == 0) ? 8'h02 : 8'h01;
         fi = (k == 1) ? 8'h02 : 8'h01;
         a = $urandom % 64;
         b = $urandom % 64;
         c = $urandom % 4;
         sa = $signed(a[5:0]);
         sb = $signed(b[5:0]);
         di = {a[5:0], 10'h155};
         dq = {b[5:0], 10'h2aa};
         p = sa * sa + sb * sb;
         t = (k == 1) ? p : (p - 1) & 13'h1fff;
         e = (p > t);
         seen = seen | e;
         wrr(OFS_SHORT_THR_LOW, t[7:0]);
         wrr(OFS_SHORT_THR_HIGH, {3'b000, t[12:8]});
         wrr(OFS_LONG_THR_LOW, t[7:0]);
         wrr(OFS_LONG_THR_HIGH, {3'b000, t[12:8]});
         wrr(OFS_ROUTING_A, 8'h60);
         if (k == 2) wrr(OFS_COMMON_CONTROL, 8'h01);
         wrr(OFS_SHORT_CONTROL, (k == 2) ? c[7:0] : 8'h80 | c[7:0]);
         wrr(OFS_LONG_CONTROL, 8'h80 | c[7:0]);
         // long window end must fall inside its last tick period
         n = 0;
         nl = 1 << (1 + c);
         per = pa_per(co, fi);
         while (lerr !== 1'b1 && n < 700) begin
            @(negedge clk_sys);
            n++;
         end
         if (e) chk1(n > (nl - 1) * per && n <= nl * per, 1'b1);
         repeat (3) @(negedge clk_sys);
         chk1(serr, e[0]);
         chk1(lerr, e[0]);
         chk1(muted, e[0]);
         rdc(OFS_SHORT_PWR_LOW, p[7:0]);
         rdc(OFS_SHORT_PWR_HIGH, {3'b000, p[12:8]});
         rdc(OFS_LONG_PWR_LOW, p[7:0]);
         rdc(OFS_LONG_PWR_HIGH, {3'b000, p[12:8]});
         wrr(OFS_COMMON_CONTROL, 8'h00);
         wrr(OFS_SHORT_CONTROL, 8'h00);
         wrr(OFS_LONG_CONTROL, 8'h00);
         repeat (3) @(negedge clk_sys);
         chk1(serr, 1'b0);
         chk1(lerr, 1'b0);
         wrr(OFS_ROUTING_A, 8'h00);
      end
      chk1(fades > 0, seen[0]);
      results();
   end
endmodule
`default_nettype wire
